// ### rtl/clock_period_divider.v
`timescale 1ns/1ps
`default_nettype none

// Divides clk_sys_in by period_in + extra_in cycles. A new length is taken
// only at the end of a period or while held, so the running ratio never sees a mix.
module clock_period_divider (
    input wire clk_sys_in,
    input wire rst_in,
    input wire hold_in,
    input wire [18:0] period_in,
    input wire [1:0] extra_in,
    output reg clk_out,
    output reg wrap_out
);

    reg [19:0] cnt_ff;
    reg [19:0] len_ff;
    reg [19:0] nxt_cnt;
    reg [19:0] nxt_len;
    reg nxt_clk;
    reg nxt_wrap;
    wire [19:0] req_len;

    assign req_len = {1'b0, period_in} + {18'h00000, extra_in};

    always @* begin
        nxt_cnt = cnt_ff + 20'h00001;
        nxt_len = len_ff;
        nxt_wrap = 1'b0;
        if (hold_in) begin
            // Held dividers park on their last count, so every one of them
            // wraps on the first edge after release; those of length 2 or more also rise.
            nxt_cnt = req_len - 20'h00001;
            nxt_len = req_len;
        end else if (cnt_ff >= len_ff - 20'h00001) begin
            nxt_cnt = 20'h00000;
            nxt_len = req_len;
            nxt_wrap = 1'b1;
        end
        nxt_clk = 1'b0;
        if (!hold_in && nxt_cnt < (nxt_len >> 1)) begin
            nxt_clk = 1'b1;
        end
    end

    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_ff <= 20'h00000;
            len_ff <= 20'h00003;
            clk_out <= 1'b0;
            wrap_out <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            len_ff <= nxt_len;
            clk_out <= nxt_clk;
            wrap_out <= nxt_wrap;
        end
    end

endmodule // clock_period_divider

`default_nettype wire

// ### rtl/output_divider_config.v
`timescale 1ns/1ps
`default_nettype none
`include "output_divider_regs.vh"

module output_divider_config (
    input wire clk_sys_in,
    input wire rst_in,
    input wire [7:0] cfg_addr_in,
    input wire [7:0] cfg_wdata_in,
    input wire cfg_wr_in,
    input wire cfg_rd_in,
    output reg [7:0] cfg_rdata_out,
    output wire [3:0] div_clk_out
);

    // Committed divide codes, the values the dividers run from.
    reg [7:0] first_output_divide_code_ff;
    reg [7:0] second_output_divide_code_ff;
    reg [7:0] third_output_divide_code_ff;
    reg [17:0] fractional_output_integer_code_ff;
    reg [27:0] fractional_output_fraction_code_ff;
    reg divider_resync_control_ff;

    // Staging bytes for the multi-byte codes.
    reg [1:0] int_high_stage_ff;
    reg [7:0] int_mid_stage_ff;
    reg [3:0] frac_top_stage_ff;
    reg [7:0] frac_upper_stage_ff;
    reg [7:0] frac_middle_stage_ff;

    // Reset codes held at full width, so staging bytes take exact slices.
    localparam [17:0] RST_INT_CODE = `RST_FRACTIONAL_INTEGER_CODE;
    localparam [27:0] RST_FRAC_CODE = `RST_FRACTIONAL_FRACTION_CODE;

    // Phase accumulator of the fractional output.
    reg [27:0] frac_acc_ff;
    reg [1:0] frac_extra_ff;

    reg [7:0] nxt_rdata;
    wire [17:0] int_candidate;
    wire int_candidate_ok;
    wire [29:0] acc_sum;
    wire [18:0] frac_period;
    wire frac_wrap;
    wire [7:0] int_code [0:2];

    wire wr_int_low;
    wire wr_frac_lower;

    assign wr_int_low = cfg_wr_in &&
        (cfg_addr_in == `OFS_OUTPUT3_INT_DIVIDE_LOW);
    assign wr_frac_lower = cfg_wr_in &&
        (cfg_addr_in == `OFS_OUTPUT3_FRACTION_LOWER);

    assign int_candidate = {int_high_stage_ff, int_mid_stage_ff,
        cfg_wdata_in};
    assign int_candidate_ok =
        (int_candidate >= `MIN_FRACTIONAL_INTEGER_CODE);

    // Integer code registers.
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            first_output_divide_code_ff <= `RST_INTEGER_DIVIDE_CODE;
            second_output_divide_code_ff <= `RST_INTEGER_DIVIDE_CODE;
            third_output_divide_code_ff <= `RST_INTEGER_DIVIDE_CODE;
            divider_resync_control_ff <= `RST_RESYNC_CONTROL;
        end else if (cfg_wr_in) begin
            // No legality check here: a divide code byte is kept whole as written; 63h keeps only bit 7.
            if (cfg_addr_in == `OFS_OUTPUT0_DIVIDE_RATIO) begin
                first_output_divide_code_ff <= cfg_wdata_in;
            end else if (cfg_addr_in == `OFS_OUTPUT1_DIVIDE_RATIO) begin
                second_output_divide_code_ff <= cfg_wdata_in;
            end else if (cfg_addr_in == `OFS_OUTPUT2_DIVIDE_RATIO) begin
                third_output_divide_code_ff <= cfg_wdata_in;
            end else if (cfg_addr_in == `OFS_OUTPUT_SOURCE_CONTROL) begin
                divider_resync_control_ff <=
                    cfg_wdata_in[`RESYNC_BIT];
            end
        end
    end

    // Fractional output integer code: upper bytes stage, low byte commits.
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            fractional_output_integer_code_ff <=
                `RST_FRACTIONAL_INTEGER_CODE;
            int_high_stage_ff <= RST_INT_CODE[17:16];
            int_mid_stage_ff <= RST_INT_CODE[15:8];
        end else if (wr_int_low) begin
            if (int_candidate_ok) begin
                fractional_output_integer_code_ff <= int_candidate;
            end else begin
                // Refused value: staging falls back to the running code.
                int_high_stage_ff <=
                    fractional_output_integer_code_ff[17:16];
                int_mid_stage_ff <=
                    fractional_output_integer_code_ff[15:8];
            end
        end else if (cfg_wr_in) begin
            if (cfg_addr_in == `OFS_OUTPUT3_INT_DIVIDE_HIGH) begin
                int_high_stage_ff <= cfg_wdata_in[`INT_HIGH_MSB:0];
            end else if (cfg_addr_in == `OFS_OUTPUT3_INT_DIVIDE_MID) begin
                int_mid_stage_ff <= cfg_wdata_in;
            end
        end
    end

    // Fraction code: the top three bytes stage, the lower byte commits.
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            fractional_output_fraction_code_ff <=
                `RST_FRACTIONAL_FRACTION_CODE;
            frac_top_stage_ff <= RST_FRAC_CODE[27:24];
            frac_upper_stage_ff <= RST_FRAC_CODE[23:16];
            frac_middle_stage_ff <= RST_FRAC_CODE[15:8];
        end else if (wr_frac_lower) begin
            fractional_output_fraction_code_ff <= {frac_top_stage_ff,
                frac_upper_stage_ff, frac_middle_stage_ff,
                cfg_wdata_in};
        end else if (cfg_wr_in) begin
            if (cfg_addr_in == `OFS_OUTPUT3_FRACTION_TOP) begin
                frac_top_stage_ff <= cfg_wdata_in[`FRAC_TOP_MSB:0];
            end else if (cfg_addr_in == `OFS_OUTPUT3_FRACTION_UPPER) begin
                frac_upper_stage_ff <= cfg_wdata_in;
            end else if (cfg_addr_in == `OFS_OUTPUT3_FRACTION_MIDDLE) begin
                frac_middle_stage_ff <= cfg_wdata_in;
            end
        end
    end

    // Read data; reserved bits and unmapped offsets read as zero.
    always @* begin
        nxt_rdata = cfg_rdata_out;
        if (cfg_rd_in) begin
            if (cfg_addr_in == `OFS_OUTPUT0_DIVIDE_RATIO) begin
                nxt_rdata = first_output_divide_code_ff;
            end else if (cfg_addr_in == `OFS_OUTPUT1_DIVIDE_RATIO) begin
                nxt_rdata = second_output_divide_code_ff;
            end else if (cfg_addr_in == `OFS_OUTPUT2_DIVIDE_RATIO) begin
                nxt_rdata = third_output_divide_code_ff;
            end else if (cfg_addr_in == `OFS_OUTPUT3_INT_DIVIDE_HIGH) begin
                nxt_rdata = {6'h00, int_high_stage_ff};
            end else if (cfg_addr_in == `OFS_OUTPUT3_INT_DIVIDE_MID) begin
                nxt_rdata = int_mid_stage_ff;
            end else if (cfg_addr_in == `OFS_OUTPUT3_INT_DIVIDE_LOW) begin
                nxt_rdata = fractional_output_integer_code_ff[7:0];
            end else if (cfg_addr_in == `OFS_OUTPUT3_FRACTION_TOP) begin
                nxt_rdata = {4'h0, frac_top_stage_ff};
            end else if (cfg_addr_in == `OFS_OUTPUT3_FRACTION_UPPER) begin
                nxt_rdata = frac_upper_stage_ff;
            end else if (cfg_addr_in == `OFS_OUTPUT3_FRACTION_MIDDLE) begin
                nxt_rdata = frac_middle_stage_ff;
            end else if (cfg_addr_in == `OFS_OUTPUT3_FRACTION_LOWER) begin
                nxt_rdata = fractional_output_fraction_code_ff[7:0];
            end else if (cfg_addr_in == `OFS_OUTPUT_SOURCE_CONTROL) begin
                nxt_rdata = {divider_resync_control_ff, 7'h00};
            end else begin
                nxt_rdata = 8'h00;
            end
        end
    end

    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_rdata_out <= 8'h00;
        end else begin
            cfg_rdata_out <= nxt_rdata;
        end
    end

    // The accumulator steps by twice the fraction code each output period;
    // its overflow lengthens the next period by one or two source cycles.
    assign acc_sum = {2'h0, frac_acc_ff} +
        {1'b0, fractional_output_fraction_code_ff, 1'b0};
    assign frac_period = {fractional_output_integer_code_ff, 1'b0};

    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            frac_acc_ff <= 28'h0000000;
            frac_extra_ff <= 2'h0;
        end else if (divider_resync_control_ff) begin
            frac_acc_ff <= 28'h0000000;
            frac_extra_ff <= 2'h0;
        end else if (frac_wrap) begin
            frac_acc_ff <= acc_sum[27:0];
            frac_extra_ff <= acc_sum[29:28];
        end
    end

    assign int_code[0] = first_output_divide_code_ff;
    assign int_code[1] = second_output_divide_code_ff;
    assign int_code[2] = third_output_divide_code_ff;

    // Odd codes above 06h are divided as written; their use is forbidden.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_int_div
            clock_period_divider u_div (
                .clk_sys_in(clk_sys_in),
                .rst_in(rst_in),
                .hold_in(divider_resync_control_ff),
                .period_in({11'h000, int_code[gi]}),
                .extra_in(2'h0),
                .clk_out(div_clk_out[gi]),
                .wrap_out()
            );
        end
    endgenerate

    clock_period_divider u_frac_div (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .hold_in(divider_resync_control_ff),
        .period_in(frac_period),
        .extra_in(frac_extra_ff),
        .clk_out(div_clk_out[3]),
        .wrap_out(frac_wrap)
    );

endmodule // output_divider_config

`default_nettype wire

// ### rtl/output_divider_regs.vh
`ifndef OUTPUT_DIVIDER_REGS_VH
`define OUTPUT_DIVIDER_REGS_VH

// Byte offsets on the serial configuration port.
`define OFS_OUTPUT0_DIVIDE_RATIO 8'h3f
`define OFS_OUTPUT1_DIVIDE_RATIO 8'h42
`define OFS_OUTPUT2_DIVIDE_RATIO 8'h45
`define OFS_OUTPUT3_INT_DIVIDE_HIGH 8'h48
`define OFS_OUTPUT3_INT_DIVIDE_MID 8'h49
`define OFS_OUTPUT3_INT_DIVIDE_LOW 8'h4a
`define OFS_OUTPUT3_FRACTION_TOP 8'h5f
`define OFS_OUTPUT3_FRACTION_UPPER 8'h60
`define OFS_OUTPUT3_FRACTION_MIDDLE 8'h61
`define OFS_OUTPUT3_FRACTION_LOWER 8'h62
`define OFS_OUTPUT_SOURCE_CONTROL 8'h63

// Field positions.
`define RESYNC_BIT 7
`define INT_HIGH_MSB 1
`define FRAC_TOP_MSB 3

// Reset values.
`define RST_INTEGER_DIVIDE_CODE 8'h03
`define RST_FRACTIONAL_INTEGER_CODE 18'h20002
`define RST_FRACTIONAL_FRACTION_CODE 28'h0000000
`define RST_RESYNC_CONTROL 1'h0

// Smallest integer code the fractional output accepts.
`define MIN_FRACTIONAL_INTEGER_CODE 18'h00003

`endif

// ### tb/output_divider_config_chk.sv
`timescale 1ns/1ps
`default_nettype none
module output_divider_config_chk (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [7:0] cfg_wdata_in,
    input wire logic cfg_wr_in,
    input wire logic cfg_rd_in,
    input wire logic [7:0] cfg_rdata_out,
    input wire logic [3:0] div_clk_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);
    // Period checks wait out three rises after any write, since a new code
    // only lands at a period boundary.
    logic [7:0] c0_ff;
    logic [7:0] sm_ff;
    logic [1:0] sh_ff;
    logic [1:0] st0_ff;
    logic [1:0] st3_ff;
    logic [17:0] n3_ff;
    logic [19:0] cnt0_ff;
    logic [19:0] cnt3_ff;
    logic [3:0] d_ff;
    logic rs_ff;
    wire logic [17:0] cand = {sh_ff, sm_ff, cfg_wdata_in};
    wire logic [3:0] rise = div_clk_out & ~d_ff;
    wire logic [7:0] wa = cfg_wr_in ? cfg_addr_in : 8'h00;
    wire logic [7:0] ra = cfg_rd_in ? cfg_addr_in : 8'h00;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            c0_ff <= 8'h03;
            sm_ff <= 8'h00;
            sh_ff <= 2'h2;
            n3_ff <= 18'h20002;
            st0_ff <= 2'h3;
            st3_ff <= 2'h3;
            cnt0_ff <= 20'h0;
            cnt3_ff <= 20'h0;
            d_ff <= 4'h0;
            rs_ff <= 1'b0;
        end else begin
            d_ff <= div_clk_out;
            cnt0_ff <= rise[0] ? 20'h1 : cnt0_ff + 20'h1;
            cnt3_ff <= rise[3] ? 20'h1 : cnt3_ff + 20'h1;
            if (cfg_wr_in) begin
                st0_ff <= 2'h3;
                st3_ff <= 2'h3;
            end
            if (!cfg_wr_in && rise[0] && st0_ff != 2'h0)
                st0_ff <= st0_ff - 2'h1;
            if (!cfg_wr_in && rise[3] && st3_ff != 2'h0)
                st3_ff <= st3_ff - 2'h1;
            if (wa == 8'h3f)
                c0_ff <= cfg_wdata_in;
            if (wa == 8'h63)
                rs_ff <= cfg_wdata_in[7];
            if (wa == 8'h48)
                sh_ff <= cfg_wdata_in[1:0];
            if (wa == 8'h49)
                sm_ff <= cfg_wdata_in;
            if (wa == 8'h4a && cand >= 18'h3)
                n3_ff <= cand;
            if (wa == 8'h4a && cand < 18'h3) begin
                sh_ff <= n3_ff[17:16];
                sm_ff <= n3_ff[15:8];
            end
        end
    end
    sequence s_held;
        (div_clk_out == 4'h0) [*3];
    endsequence
    AST_RD_CODE0: assert property (
        ra == 8'h3f |=> cfg_rdata_out == $past(c0_ff))
        else $error("code read mismatch");
    AST_RD_INT_LOW: assert property (
        ra == 8'h4a |=> cfg_rdata_out == $past(n3_ff[7:0]))
        else $error("integer code read mismatch");
    AST_RD_INT_MID: assert property (
        ra == 8'h49 |=> cfg_rdata_out == $past(sm_ff))
        else $error("staged byte read mismatch");
    AST_RD_UNMAPPED: assert property (
        ra == 8'h40 |=> cfg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    AST_PERIOD0: assert property (
        rise[0] && st0_ff == 2'h0 |-> cnt0_ff == {12'h0, c0_ff})
        else $error("output 0 period wrong");
    AST_PERIOD3: assert property (
        rise[3] && st3_ff == 2'h0 |-> cnt3_ff >= {1'b0, n3_ff, 1'b0}
        && cnt3_ff <= {1'b0, n3_ff, 1'b0} + 20'h2)
        else $error("output 3 period wrong");
    AST_HOLD: assert property (
        wa == 8'h63 && cfg_wdata_in[7] |-> ##2 s_held)
        else $error("dividers not held");
    AST_RELEASE: assert property (
        rs_ff && wa == 8'h63 && !cfg_wdata_in[7]
        |-> ##[1:3] div_clk_out == 4'hf)
        else $error("dividers not released together");
endmodule // output_divider_config_chk
bind output_divider_config output_divider_config_chk u_chk (.clk_sys_in,
    .rst_in, .cfg_addr_in, .cfg_wdata_in, .cfg_wr_in, .cfg_rd_in,
    .cfg_rdata_out, .div_clk_out);
`default_nettype wire

// ### tb/output_divider_config_test.sv
`timescale 1ns/1ps
`default_nettype none
module output_divider_config_test;
    logic clk_sys_in;
    logic rst_in;
    logic [7:0] cfg_addr_in;
    logic [7:0] cfg_wdata_in;
    logic cfg_wr_in;
    logic cfg_rd_in;
    logic [7:0] cfg_rdata_out;
    logic [3:0] div_clk_out;
    int num_errors;
    int check_count;
    int per;
    int hi;
    int k;
    logic [15:0] rv [11] = '{16'h3f03, 16'h4203, 16'h4503, 16'h4802,
        16'h4900, 16'h4a02, 16'h5f00, 16'h6000, 16'h6100, 16'h6200, 16'h4000};
    logic [7:0] cd [4] = '{8'h03, 8'h06, 8'ha0, 8'h08};
    output_divider_config u_dut (.clk_sys_in, .rst_in, .cfg_addr_in,
        .cfg_wdata_in, .cfg_wr_in, .cfg_rd_in, .cfg_rdata_out, .div_clk_out);
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_int(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            num_errors++;
            $display("[ERR] %0t count got %0d exp %0d", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        cfg_addr_in <= a;
        cfg_wdata_in <= d;
        cfg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        cfg_wr_in <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        cfg_addr_in <= a;
        cfg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        cfg_rd_in <= 1'b0;
        #1 cmp_byte(cfg_rdata_out, exp);
    endtask
    // The first full period after a write may still run on the old code,
    // so counting starts at the second rise seen.
    task automatic meas(input int m, input int span);
        int n;
        int r;
        logic p;
        n = 0;
        r = 0;
        p = 1'b1;
        per = 0;
        hi = 0;
        while (r < span + 2) begin
            @(posedge clk_sys_in);
            #1;
            if (div_clk_out[m] === 1'b1 && !p)
                r++;
            p = div_clk_out[m];
            if (r >= 2 && r < span + 2)
                per++;
            if (r >= 2 && r < span + 2 && p)
                hi++;
            n++;
            if (n > 4000) begin
                num_errors++;
                $display("[ERR] %0t no clock edge", $time);
                end_sim();
            end
        end
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        rst_in = 1'b1;
        cfg_addr_in = 8'h00;
        cfg_wdata_in = 8'h00;
        cfg_wr_in = 1'b0;
        cfg_rd_in = 1'b0;
        num_errors = 0;
        check_count = 0;
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        foreach (rv[i])
            rd_chk(rv[i][15:8], rv[i][7:0]);
        $display("reset values done");
        foreach (cd[i]) begin
            wr_reg(8'h3f + 8'(3 * (i % 3)), cd[i]);
            rd_chk(8'h3f + 8'(3 * (i % 3)), cd[i]);
            meas(i % 3, 1);
            cmp_int(per, cd[i]);
            cmp_int(hi, cd[i] / 2);
        end
        $display("integer outputs done");
        wr_reg(8'h48, 8'h00);
        wr_reg(8'h49, 8'h00);
        wr_reg(8'h4a, 8'h05);
        // Output 3 starts on its reset period, far too long to wait out, so
        // a resync pulse restarts it on the new code.
        wr_reg(8'h63, 8'h80);
        rd_chk(8'h63, 8'h80);
        wr_reg(8'h63, 8'h00);
        meas(3, 1);
        cmp_int(per, 10);
        wr_reg(8'h4a, 8'h02);
        rd_chk(8'h4a, 8'h05);
        wr_reg(8'h49, 8'h01);
        rd_chk(8'h49, 8'h01);
        meas(3, 1);
        cmp_int(per, 10);
        wr_reg(8'h4a, 8'h00);
        meas(3, 1);
        cmp_int(per, 512);
        wr_reg(8'h49, 8'h00);
        wr_reg(8'h4a, 8'h05);
        wr_reg(8'h5f, 8'h04);
        wr_reg(8'h62, 8'h00);
        rd_chk(8'h5f, 8'h04);
        meas(3, 2);
        cmp_int(per, 21);
        $display("fractional output done");
        wr_reg(8'h63, 8'h80);
        rd_chk(8'h63, 8'h80);
        repeat (4) begin
            @(posedge clk_sys_in);
            #1 cmp_byte({4'h0, div_clk_out}, 8'h00);
        end
        wr_reg(8'h63, 8'h00);
        #1 k = 0;
        while (div_clk_out === 4'h0 && k < 8) begin
            @(posedge clk_sys_in);
            #1 k++;
        end
        cmp_byte({4'h0, div_clk_out}, 8'h0f);
        $display("resync done");
        end_sim();
    end
endmodule // output_divider_config_test
`default_nettype wire
